/* design/ddr_burst_sram_port_logic.sv */
// Burst SRAM port logic: write and read ports on a shared address bus, DDR data, echo clocks.
// Assumes link clocks and pins are sampled by sys_clk, far faster than the link clocks.
`timescale 1ns/10ps
`include "sram_port_regs.svh"

// ----------------------------------------------------------------
// Read data buffer
// ----------------------------------------------------------------
module sram_word_fifo #(
	parameter int W     = 18,
	parameter int DEPTH = 4
) (
	input  wire logic         sys_clk,
	input  wire logic         reset_n,
	input  wire logic         ce,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [W-1:0] store [DEPTH];
	logic [PW-1:0] wr_ptr_reg;
	logic [PW-1:0] rd_ptr_reg;
	logic [PW:0]   count_reg;
	wire push = in_valid & in_ready & ce;
	wire pop  = out_valid & out_ready & ce;

	assign in_ready  = (count_reg != (PW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign out_data  = store[rd_ptr_reg];

	always_ff @(posedge sys_clk) begin
		if (push)
			store[wr_ptr_reg] <= in_data;
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
			count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule

// ----------------------------------------------------------------
// Port logic
// ----------------------------------------------------------------
module ddr_burst_sram_port_logic #(
	parameter int ADDR_W = `ADDR_W_NARROW,
	parameter int DATA_W = `DATA_W_NARROW
) (
	input  wire logic                sys_clk,
	input  wire logic                reset_n,
	input  wire logic                ce,
	input  wire logic                k,
	input  wire logic                k_n,
	input  wire logic                c,
	input  wire logic                c_n,
	input  wire logic                wr_port_sel_n,
	input  wire logic                rd_port_sel_n,
	input  wire logic [DATA_W/`LANE_BITS-1:0] byte_lane_sel_n,
	input  wire logic [ADDR_W-1:0]   addr,
	input  wire logic [DATA_W-1:0]   wr_data,
	output logic      [DATA_W-1:0]   rd_data,
	output logic      [DATA_W-1:0]   rd_data_oe,
	output logic                     echo_strobe_pos,
	output logic                     echo_strobe_neg
);
	localparam int LANES = DATA_W / `LANE_BITS;
	localparam int PIN_W = 4 + 2 + LANES + ADDR_W + DATA_W;
	localparam int DEPTH = 1 << ADDR_W;

	// ----------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ----------------------------------------------------------------
	// Every pin, clocks included, passes the same two flops, so data keeps its
	// alignment to the sampled clock edges.
	logic [PIN_W-1:0] pins_s1_reg;
	logic [PIN_W-1:0] pins_s2_reg;
	sram_port_pkg::link_clk_t clk_prev_reg;
	wire [PIN_W-1:0] pins_raw = {k, k_n, c, c_n, wr_port_sel_n, rd_port_sel_n,
		byte_lane_sel_n, addr, wr_data};

	wire sram_port_pkg::link_clk_t clk_s = pins_s2_reg[PIN_W-1 -: 4];
	wire                 wsel_n_s = pins_s2_reg[PIN_W-5];
	wire                 rsel_n_s = pins_s2_reg[PIN_W-6];
	wire [LANES-1:0]     lane_n_s = pins_s2_reg[DATA_W+ADDR_W +: LANES];
	wire [ADDR_W-1:0]    addr_s   = pins_s2_reg[DATA_W +: ADDR_W];
	wire [DATA_W-1:0]    data_s   = pins_s2_reg[DATA_W-1:0];

	// Edges count only once both synchroniser stages and the previous-sample
	// flop hold real pin values, so a link clock that is already high at reset
	// release is not mistaken for a fresh rising edge.
	logic [1:0] strap_cnt_reg;
	logic       single_mode_reg;
	wire        link_live = (strap_cnt_reg == `STRAP_WAIT);

	wire k_rise   = ce & link_live & clk_s.k & ~clk_prev_reg.k;
	wire kn_rise  = ce & link_live & clk_s.k_n & ~clk_prev_reg.k_n;
	wire c_rise   = ce & link_live & clk_s.c & ~clk_prev_reg.c;
	wire cn_rise  = ce & link_live & clk_s.c_n & ~clk_prev_reg.c_n;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pins_s1_reg  <= '0;
			pins_s2_reg  <= '0;
			clk_prev_reg <= '0;
		end else if (ce) begin
			pins_s1_reg  <= pins_raw;
			pins_s2_reg  <= pins_s1_reg;
			clk_prev_reg <= clk_s;
		end
	end

	// ----------------------------------------------------------------
	// Single-clock strap
	// ----------------------------------------------------------------
	// The strap is taken once, after the synchronisers have filled; later
	// changes of the output clocks do not move the mode.

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			strap_cnt_reg   <= '0;
			single_mode_reg <= 1'b0;
		end else if (ce && strap_cnt_reg != `STRAP_WAIT) begin
			strap_cnt_reg <= strap_cnt_reg + 2'h1;
			if (strap_cnt_reg == `STRAP_WAIT - 2'h1)
				single_mode_reg <= clk_s.c & clk_s.c_n;
		end
	end

	wire oc_rise  = single_mode_reg ? k_rise : c_rise;
	wire ocn_rise = single_mode_reg ? kn_rise : cn_rise;

	// ----------------------------------------------------------------
	// Write port and array
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] mem_lo [DEPTH];
	logic [DATA_W-1:0] mem_hi [DEPTH];
	logic              wr_pend_reg;
	logic [DATA_W-1:0] wr_lo_reg;
	logic [LANES-1:0]  wr_lane_lo_reg;

	wire wr_start  = k_rise & ~wsel_n_s;
	wire wr_commit = kn_rise & wr_pend_reg;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_pend_reg    <= 1'b0;
			wr_lo_reg      <= '0;
			wr_lane_lo_reg <= '0;
		end else begin
			if (wr_start) begin
				wr_lo_reg      <= data_s;
				wr_lane_lo_reg <= ~lane_n_s;
			end
			if (k_rise)
				wr_pend_reg <= ~wsel_n_s;
			else if (wr_commit)
				wr_pend_reg <= 1'b0;
		end
	end

	// Both words land together at the negative rise, addressed by the bus then.
	always_ff @(posedge sys_clk) begin
		if (wr_commit) begin
			for (int l = 0; l < LANES; l++) begin
				if (wr_lane_lo_reg[l])
					mem_lo[addr_s][l*`LANE_BITS +: `LANE_BITS] <=
						wr_lo_reg[l*`LANE_BITS +: `LANE_BITS];
				if (!lane_n_s[l])
					mem_hi[addr_s][l*`LANE_BITS +: `LANE_BITS] <=
						data_s[l*`LANE_BITS +: `LANE_BITS];
			end
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	sram_port_pkg::fetch_state_t fetch_state_reg;
	sram_port_pkg::fetch_state_t fetch_state_next;
	logic              rd_pend_reg;
	logic [ADDR_W-1:0] rd_addr_reg;
	logic [ADDR_W-1:0] fetch_addr_reg;
	logic              fifo_in_ready;
	logic              fifo_out_valid;
	logic [DATA_W-1:0] fifo_out_data;
	// Popped by the output stage below, one word per output clock rise.
	logic              fifo_pop;

	wire fetch_go   = k_rise & rd_pend_reg;
	wire fifo_push  = (fetch_state_reg != sram_port_pkg::FETCH_IDLE);
	// The array is read only when the word is pushed, after any write begun on
	// the previous positive rise has already committed at its negative rise.
	wire [DATA_W-1:0] fetch_word = (fetch_state_reg == sram_port_pkg::FETCH_LO) ?
		mem_lo[fetch_addr_reg] : mem_hi[fetch_addr_reg];

	always_comb begin
		fetch_state_next = fetch_state_reg;
		unique case (fetch_state_reg)
			sram_port_pkg::FETCH_IDLE: begin
				if (fetch_go)
					fetch_state_next = sram_port_pkg::FETCH_LO;
			end
			sram_port_pkg::FETCH_LO: begin
				if (fifo_in_ready && ce)
					fetch_state_next = sram_port_pkg::FETCH_HI;
			end
			sram_port_pkg::FETCH_HI: begin
				if (fifo_in_ready && ce)
					fetch_state_next = sram_port_pkg::FETCH_IDLE;
			end
			default: fetch_state_next = sram_port_pkg::FETCH_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			fetch_state_reg <= sram_port_pkg::FETCH_IDLE;
			rd_pend_reg     <= 1'b0;
			rd_addr_reg     <= '0;
			fetch_addr_reg  <= '0;
		end else begin
			fetch_state_reg <= fetch_state_next;
			if (fetch_go)
				fetch_addr_reg <= rd_addr_reg;
			if (k_rise) begin
				rd_pend_reg <= ~rsel_n_s;
				if (!rsel_n_s)
					rd_addr_reg <= addr_s;
			end
		end
	end

	sram_word_fifo #(
		.W     (DATA_W),
		.DEPTH (`FIFO_DEPTH)
	) read_buf (
		.sys_clk   (sys_clk),
		.reset_n   (reset_n),
		.ce        (ce),
		.in_valid  (fifo_push),
		.in_ready  (fifo_in_ready),
		.in_data   (fetch_word),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out_data)
	);

	// ----------------------------------------------------------------
	// Output drive and echo clocks
	// ----------------------------------------------------------------
	// The low word waits for a positive output rise, the high word follows on
	// the negative rise, so a burst never straddles a positive edge.
	logic half_reg;
	logic [DATA_W-1:0] rd_data_reg;
	logic              oe_reg;
	logic              echo_pos_reg;
	logic              echo_neg_reg;
	wire pop_lo   = oc_rise & ~half_reg & fifo_out_valid;
	wire pop_hi   = ocn_rise & half_reg & fifo_out_valid;
	assign fifo_pop = pop_lo | pop_hi;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			half_reg     <= 1'b0;
			rd_data_reg  <= '0;
			oe_reg       <= 1'b0;
			echo_pos_reg <= 1'b0;
			echo_neg_reg <= 1'b0;
		end else if (ce) begin
			echo_pos_reg <= single_mode_reg ? clk_s.k : clk_s.c;
			echo_neg_reg <= single_mode_reg ? clk_s.k_n : clk_s.c_n;
			if (fifo_pop)
				rd_data_reg <= fifo_out_data;
			if (pop_lo) begin
				half_reg <= 1'b1;
				oe_reg   <= 1'b1;
			end else if (pop_hi) begin
				half_reg <= 1'b0;
			end else if (oc_rise && !half_reg) begin
				oe_reg <= 1'b0;
			end
		end
	end

	assign rd_data         = rd_data_reg;
	assign rd_data_oe      = {DATA_W{oe_reg}};
	assign echo_strobe_pos = echo_pos_reg;
	assign echo_strobe_neg = echo_neg_reg;
endmodule

/* design/sram_port_regs.svh */
// Constants for the burst SRAM port logic: reset values, field sizes, strap timing.
// Assumes it is included once by the package and the design file by its bare name.
//
// Function
// - Write data captured on rising edges of both input clocks, 18 or 36 bits.
// - Write select low at positive input clock rise begins a write.
// - Write select high deselects the write port; write data is ignored.
// - Each lane select is sampled on the same edge as its data word.
// - Lane select n governs nine-bit data group n.
// - A lane sampled high leaves that stored byte unchanged.
// - Read address taken on positive rise, write address on negative rise.
// - 19 address bits narrow, 18 wide; each address holds a two-word burst.
// - Address is ignored for a port whose select is inactive.
// - Read data launched on output clock rises, input clocks in single-clock mode.
// - Read select low at positive input clock rise begins a read.
// - On read deselect, finish the burst, then tristate after next positive output rise.
// - Every read returns exactly two sequential words of one location.
// - Accesses start only on positive input clock rises, never negative.
// - Two free-running echo clocks follow output clocks, or input clocks single-clock.
// - Low word driven after the next positive input rise, high word one edge later.
// - Write word one on select edge; address and word two on negative rise.
// - A read of a just-written location returns the newest written data.
`ifndef SRAM_PORT_REGS_SVH
`define SRAM_PORT_REGS_SVH

`define LANE_BITS      9
`define ADDR_W_NARROW  19
`define DATA_W_NARROW  18
`define STRAP_WAIT     2'h3
`define FIFO_DEPTH     4
`define RST_SYNC       1'b1

`endif

/* design/sram_port_pkg.sv */
// Types shared by the burst SRAM port logic.
// Assumes sram_port_regs.svh sits beside it.
`include "sram_port_regs.svh"
package sram_port_pkg;
	typedef struct packed {
		logic k;
		logic k_n;
		logic c;
		logic c_n;
	} link_clk_t;

	typedef enum logic [2:0] {
		FETCH_IDLE = 3'h1,
		FETCH_LO   = 3'h2,
		FETCH_HI   = 3'h4
	} fetch_state_t;
endpackage

/* verif/sram_port_monitor.sv */
// Checker for the read side and echo pins of the burst SRAM port logic.
// Assumes ce is held high and the output clock pair runs freely or is strapped high.
`timescale 1ns/10ps
module sram_port_monitor #(
	parameter int DATA_W = 18
) (
	input wire logic              sys_clk,
	input wire logic              reset_n,
	input wire logic              k,
	input wire logic              k_n,
	input wire logic              c,
	input wire logic              c_n,
	input wire logic              rd_port_sel_n,
	input wire logic [DATA_W-1:0] rd_data,
	input wire logic [DATA_W-1:0] rd_data_oe,
	input wire logic              echo_strobe_pos,
	input wire logic              echo_strobe_neg
);
	logic [2:0] up_cnt_reg;
	logic       echo_ref_pos;
	logic       echo_ref_neg;
	// The pin synchronisers and the mode strap need four cycles after release.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			up_cnt_reg <= 3'h0;
		else if (up_cnt_reg != 3'h4)
			up_cnt_reg <= up_cnt_reg + 3'h1;
	end
	// With both output clocks strapped high the echoes follow the input pair.
	assign echo_ref_pos = (c & c_n) ? k : c;
	assign echo_ref_neg = (c & c_n) ? k_n : c_n;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence read_req_s;
		$rose(k) ##0 !rd_port_sel_n;
	endsequence
	sequence out_rise_s;
		$rose(echo_strobe_pos);
	endsequence
	echo_pos_a: assert property (up_cnt_reg == 3'h4 |-> echo_strobe_pos == $past(echo_ref_pos, 3))
		else $error("positive echo lost its clock");
	echo_neg_a: assert property (up_cnt_reg == 3'h4 |-> echo_strobe_neg == $past(echo_ref_neg, 3))
		else $error("negative echo lost its clock");
	oe_lanes_a: assert property (rd_data_oe == '0 || rd_data_oe == '1)
		else $error("read enables split");
	oe_start_a: assert property ($rose(rd_data_oe[0]) |-> out_rise_s)
		else $error("read drive began off the output clock");
	oe_stop_a: assert property ($fell(rd_data_oe[0]) |-> out_rise_s)
		else $error("read drive ended off the output clock");
	data_edge_a: assert property (up_cnt_reg == 3'h4 && $changed(rd_data)
		|-> $rose(echo_strobe_pos) || $rose(echo_strobe_neg)) else $error("read data moved off edge");
	read_answer_a: assert property (read_req_s |-> ##[1:40] $rose(echo_strobe_neg) && rd_data_oe[0])
		else $error("read got no burst");
	burst_len_a: assert property ($rose(rd_data_oe[0]) |-> rd_data_oe[0] [*8])
		else $error("burst cut short");
endmodule
bind ddr_burst_sram_port_logic sram_port_monitor #(.DATA_W(DATA_W)) i_monitor (
	.sys_clk(sys_clk), .reset_n(reset_n), .k(k), .k_n(k_n), .c(c), .c_n(c_n),
	.rd_port_sel_n(rd_port_sel_n), .rd_data(rd_data), .rd_data_oe(rd_data_oe),
	.echo_strobe_pos(echo_strobe_pos), .echo_strobe_neg(echo_strobe_neg));

/* verif/mem_ctrl_model.sv */
// Model of the external memory controller: free-running link clocks and request pins.
// Assumes sys_clk is the block clock; pins change two falling edges after a link edge.
`timescale 1ns/10ps
module mem_ctrl_model (
	input wire logic   sys_clk,
	input wire logic   strap_single,
	output logic       k,
	output logic       k_n,
	output logic       c,
	output logic       c_n,
	output logic       wr_port_sel_n,
	output logic       rd_port_sel_n,
	output logic [1:0] byte_lane_sel_n,
	output logic [18:0] addr,
	output logic [17:0] wr_data
);
	// The output pair runs with the input pair, unless the strap holds both
	// output clocks high from reset onward to pick single-clock mode.
	assign k_n = ~k;
	assign c   = strap_single ? 1'b1 : k;
	assign c_n = strap_single ? 1'b1 : k_n;
	initial begin
		wr_port_sel_n = 1'b1;
		rd_port_sel_n = 1'b1;
		byte_lane_sel_n = 2'h3;
		addr = 19'h00000;
		wr_data = 18'h00000;
		k = 1'b0;
		#7;
		forever #160 k = ~k;
	end
	task automatic slot(input logic neg);
		if (neg)
			@(posedge k_n);
		else
			@(posedge k);
		repeat (2) @(negedge sys_clk);
	endtask
	task automatic access(input logic rd, input logic wr, input logic [18:0] raddr,
		input logic [18:0] waddr, input logic [17:0] d0, input logic [17:0] d1,
		input logic [1:0] l0, input logic [1:0] l1);
		rd_port_sel_n <= ~rd;
		wr_port_sel_n <= ~wr;
		addr <= raddr;
		wr_data <= d0;
		byte_lane_sel_n <= l0;
		slot(1'b0);
		rd_port_sel_n <= 1'b1;
		wr_port_sel_n <= 1'b1;
		addr <= waddr;
		wr_data <= d1;
		byte_lane_sel_n <= l1;
		slot(1'b1);
	endtask
endmodule

/* verif/ddr_burst_sram_port_logic_tb_top.sv */
// Self-checking bench for the burst SRAM port logic.
// Assumes the controller model drives every link pin.
`timescale 1ns/10ps
module ddr_burst_sram_port_logic_tb_top;
	logic sys_clk, reset_n, k, k_n, c, c_n, wsel_n, rsel_n, echo_p, echo_n, single_strap;
	logic [1:0]  lanes_n;
	logic [18:0] addr;
	logic [17:0] wr_data, rd_data, rd_data_oe;
	int          num_errors, check_count;
	always #20 sys_clk = ~sys_clk;
	mem_ctrl_model i_ctrl (.sys_clk(sys_clk), .strap_single(single_strap), .k(k), .k_n(k_n),
		.c(c), .c_n(c_n),
		.wr_port_sel_n(wsel_n), .rd_port_sel_n(rsel_n), .byte_lane_sel_n(lanes_n),
		.addr(addr), .wr_data(wr_data));
	ddr_burst_sram_port_logic i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .ce(1'b1),
		.k(k), .k_n(k_n), .c(c), .c_n(c_n), .wr_port_sel_n(wsel_n), .rd_port_sel_n(rsel_n),
		.byte_lane_sel_n(lanes_n), .addr(addr), .wr_data(wr_data), .rd_data(rd_data),
		.rd_data_oe(rd_data_oe), .echo_strobe_pos(echo_p), .echo_strobe_neg(echo_n));
	task automatic final_report();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic check(input logic [17:0] got, input logic [17:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Polls for the low word, then takes the high word one output half period later.
	task automatic read_back(input logic [17:0] lo, input logic [17:0] hi);
		int n;
		n = 0;
		while (rd_data_oe[0] !== 1'b1 && n < 40) begin
			@(negedge sys_clk);
			n++;
		end
		if (rd_data_oe[0] !== 1'b1) begin
			check(rd_data_oe, 18'h3FFFF);
			final_report();
		end
		check(rd_data, lo);
		repeat (4) @(negedge sys_clk);
		check(rd_data, hi);
		repeat (5) @(negedge sys_clk);
		check(rd_data_oe, 18'h00000);
		i_ctrl.slot(1'b0);
	endtask
	function automatic logic [17:0] merge(input logic [17:0] old, input logic [17:0] nw,
		input logic [1:0] l_n);
		merge = old;
		for (int i = 0; i < 2; i++) begin
			if (!l_n[i])
				merge[i*9 +: 9] = nw[i*9 +: 9];
		end
	endfunction
	task automatic t_write_read();
		i_ctrl.access(1'b0, 1'b1, 19'h0, 19'h00000, 18'h1A5A5, 18'h2C3C3, 2'h0, 2'h0);
		i_ctrl.access(1'b0, 1'b1, 19'h0, 19'h7FFFF, 18'h0F00F, 18'h30F0F, 2'h0, 2'h0);
		i_ctrl.access(1'b1, 1'b0, 19'h00000, 19'h0, 18'h0, 18'h0, 2'h3, 2'h3);
		read_back(18'h1A5A5, 18'h2C3C3);
		i_ctrl.access(1'b1, 1'b0, 19'h7FFFF, 19'h0, 18'h0, 18'h0, 2'h3, 2'h3);
		read_back(18'h0F00F, 18'h30F0F);
	endtask
	task automatic t_lanes_forward();
		i_ctrl.access(1'b0, 1'b1, 19'h0, 19'h00000, 18'h00000, 18'h00000, 2'h1, 2'h2);
		i_ctrl.access(1'b1, 1'b0, 19'h00000, 19'h0, 18'h0, 18'h0, 2'h3, 2'h3);
		read_back(merge(18'h1A5A5, 18'h0, 2'h1), merge(18'h2C3C3, 18'h0, 2'h2));
	endtask
	task automatic t_deselect();
		i_ctrl.access(1'b0, 1'b0, 19'h00000, 19'h00000, 18'h3FFFF, 18'h3FFFF, 2'h0, 2'h0);
		i_ctrl.access(1'b1, 1'b1, 19'h7FFFF, 19'h00001, 18'h12345, 18'h2ABCD, 2'h0, 2'h0);
		read_back(18'h0F00F, 18'h30F0F);
		i_ctrl.access(1'b1, 1'b0, 19'h00000, 19'h0, 18'h0, 18'h0, 2'h3, 2'h3);
		read_back(merge(18'h1A5A5, 18'h0, 2'h1), merge(18'h2C3C3, 18'h0, 2'h2));
		i_ctrl.access(1'b1, 1'b0, 19'h00001, 19'h0, 18'h0, 18'h0, 2'h3, 2'h3);
		read_back(18'h12345, 18'h2ABCD);
	endtask
	// A second reset with the output pair strapped high retakes the clock mode.
	task automatic t_single_clock();
		reset_n = 1'b0;
		single_strap = 1'b1;
		repeat (6) @(negedge sys_clk);
		reset_n = 1'b1;
		repeat (2) i_ctrl.slot(1'b0);
		i_ctrl.access(1'b0, 1'b1, 19'h0, 19'h00002, 18'h3C00F, 18'h003FF, 2'h0, 2'h0);
		i_ctrl.access(1'b1, 1'b0, 19'h00002, 19'h0, 18'h0, 18'h0, 2'h3, 2'h3);
		read_back(18'h3C00F, 18'h003FF);
	endtask
	initial begin
		sys_clk = 1'b0;
		reset_n = 1'b0;
		single_strap = 1'b0;
		num_errors = 0;
		check_count = 0;
		repeat (6) @(negedge sys_clk);
		reset_n = 1'b1;
		repeat (2) i_ctrl.slot(1'b0);
		t_write_read();
		t_lanes_forward();
		t_deselect();
		t_single_clock();
		final_report();
	end
endmodule
